// [design/imc_consts.svh]
/*
 * holds the register offsets, field positions, reset values and codes of the
 * two-wire master control slice.
 * assumes it is included by its bare name wherever these constants are needed.
 */
`ifndef IMC_CONSTS_SVH
`define IMC_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define IMC_OFS_INT_ENABLE 12'h304
`define IMC_OFS_INT_DISABLE 12'h308
`define IMC_OFS_ERROR_SOURCE 12'h4C4
`define IMC_OFS_UNIT_ENABLE 12'h500
`define IMC_OFS_EVENT_STATUS 12'h600

// ****************************************************************
// event bit positions, shared by enable, disable and status
// ****************************************************************
`define IMC_BIT_HALTED 1
`define IMC_BIT_RX_READY 2
`define IMC_BIT_TX_SENT 7
`define IMC_BIT_ERROR 9
`define IMC_BIT_BYTE_BOUNDARY 14
`define IMC_BIT_PAUSED 18

// ****************************************************************
// error source bit positions
// ****************************************************************
`define IMC_BIT_OVERRUN 0
`define IMC_BIT_ADDR_NACK 1
`define IMC_BIT_DATA_NACK 2

// ****************************************************************
// unit enable field, reset values and bit counter marks
// ****************************************************************
`define IMC_UNIT_FIELD_W 4
`define IMC_UNIT_ON_CODE 4'h5
`define IMC_UNIT_OFF_CODE 4'h0
`define IMC_RST_EVENTS 6'h00
`define IMC_RST_ERRORS 3'h0
`define IMC_ACK_BIT_NUM 4'h9
`define IMC_LAST_DATA_BIT 4'h8

`endif

// [design/imc_pkg.sv]
/*
 * holds the types of the two-wire master control slice.
 * assumes the constants header is compiled alongside.
 */
package imc_pkg;

  // ****************************************************************
  // transfer phase on the link
  // ****************************************************************
  typedef enum logic [1:0] {
    IMC_PH_IDLE,
    IMC_PH_ADDRESS,
    IMC_PH_DATA
  } imc_phase_t;

  // ****************************************************************
  // internal event index order
  // ****************************************************************
  typedef logic [5:0] imc_events_t;
  typedef logic [2:0] imc_errors_t;

endpackage

// [design/imc_sync.sv]
/*
 * holds a two flip-flop synchroniser for single-bit levels.
 * assumes the input comes from outside the pclk domain and idles high.
 */
`timescale 1ns/10ps

module imc_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q; // first stage, read only by the second

  // ****************************************************************
  // two stage capture
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle-high reset level, so no false edge follows reset
      meta_q <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [design/imc_sticky.sv]
/*
 * holds a bank of sticky flags where a set beats a clear in the same cycle.
 * assumes set and clear are on the pclk domain.
 */
`timescale 1ns/10ps

module imc_sticky #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // per-bit set and clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flag_q
);

  // ****************************************************************
  // set wins over clear
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= set | (flag_q & ~clr);
    end
  end

endmodule

// [design/imc_ctrl.sv]
/*
 * holds the control and status slice of the two-wire master: apb registers,
 * event interrupts, error sources, unit enable and ack-slot watching on the link.
 * assumes the shifter drives the event pulses on pclk and the bus pins arrive
 * asynchronously.
 */
// Overview of operation
// - writing one disables event interrupt; reads enabled
// - paused only after read ack when requested
// - overrun when byte arrives before previous read
// - address nack flag sticks until one written
// - data nack flag sticks until one written
// - unit on at code five, off otherwise
`timescale 1ns/10ps
`include "imc_consts.svh"

module imc_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // events from the shifter
  input wire logic bus_halted_event,
  input wire logic rx_byte_ready_event,
  input wire logic tx_byte_sent_event,
  input wire logic rx_hold_read,
  input wire logic xfer_start,
  input wire logic read_txn,
  input wire logic pause_req,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  // outputs
  output logic irq,
  output logic two_wire_unit_on,
  output logic byte_boundary_event,
  output logic paused_event,
  output logic error_event
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic scl_s; // synchronised clock line
  logic sda_s; // synchronised data line
  logic scl_prev_q; // last synchronised clock level
  logic scl_rise; // rising edge seen
  logic scl_fall; // falling edge seen
  logic [3:0] bit_cnt_q; // bits of the current byte
  logic nack_q; // ack slot sampled high
  logic pause_pend_q; // pause requested, not yet served
  logic rx_pend_q; // received byte not yet read
  imc_pkg::imc_phase_t phase_q; // address or data phase
  logic ack_done; // ack slot just ended
  logic [`IMC_UNIT_FIELD_W-1:0] unit_field_q; // unit enable field
  imc_pkg::imc_events_t inten_q; // interrupt enables
  imc_pkg::imc_events_t ev_set; // event pulses this cycle
  imc_pkg::imc_events_t ev_stat; // sticky event status
  imc_pkg::imc_events_t ev_clr; // read clear of status
  imc_pkg::imc_events_t stat_seen_q; // status bits shown to the reader
  imc_pkg::imc_errors_t err_set; // error sets this cycle
  imc_pkg::imc_errors_t err_clr; // software clears
  imc_pkg::imc_errors_t err_q; // error source flags
  logic setup; // apb setup cycle
  logic access; // apb access completes
  logic wr; // write completes
  logic rd; // read completes
  logic [31:0] rd_val; // read mux
  logic mapped; // address decodes
  logic unit_on; // decoded enable

  // spread six events over their word positions
  function automatic logic [31:0] imc_pack(input imc_pkg::imc_events_t e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`IMC_BIT_HALTED] = e[0];
    w[`IMC_BIT_RX_READY] = e[1];
    w[`IMC_BIT_TX_SENT] = e[2];
    w[`IMC_BIT_ERROR] = e[3];
    w[`IMC_BIT_BYTE_BOUNDARY] = e[4];
    w[`IMC_BIT_PAUSED] = e[5];
    return w;
  endfunction
  // gather six events from their word positions
  function automatic imc_pkg::imc_events_t imc_unpack(input logic [31:0] w);
    imc_pkg::imc_events_t e;
    e = {w[`IMC_BIT_PAUSED], w[`IMC_BIT_BYTE_BOUNDARY], w[`IMC_BIT_ERROR],
         w[`IMC_BIT_TX_SENT], w[`IMC_BIT_RX_READY], w[`IMC_BIT_HALTED]};
    return e;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  imc_sync u_sync_scl (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(scl_in),
    .sync_out(scl_s)
  );
  imc_sync u_sync_sda (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sda_in),
    .sync_out(sda_s)
  );
  // edge finder on the synchronised clock line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
    end
  end
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign unit_on = (unit_field_q == `IMC_UNIT_ON_CODE);
  assign ack_done = unit_on & scl_fall & (bit_cnt_q == `IMC_ACK_BIT_NUM);

  // ****************************************************************
  // byte and ack-slot tracking
  // ****************************************************************
  // bit counter and nack sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_q <= 4'h0;
      nack_q <= 1'b0;
    end else if (!unit_on || xfer_start) begin
      bit_cnt_q <= 4'h0;
      nack_q <= 1'b0;
    end else if (ack_done) begin
      bit_cnt_q <= 4'h0;
    end else if (scl_rise && phase_q != imc_pkg::IMC_PH_IDLE) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      // ack slot sampled on its rising edge
      if (bit_cnt_q == `IMC_LAST_DATA_BIT) begin
        nack_q <= sda_s;
      end
    end
  end
  // phase: the first byte after a start is the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= imc_pkg::IMC_PH_IDLE;
    end else if (!unit_on || bus_halted_event) begin
      phase_q <= imc_pkg::IMC_PH_IDLE;
    end else if (xfer_start) begin
      phase_q <= imc_pkg::IMC_PH_ADDRESS;
    end else if (ack_done) begin
      phase_q <= imc_pkg::IMC_PH_DATA;
    end
  end
  // pause request held until a read ack slot serves it or the unit goes off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_pend_q <= 1'b0;
    end else if (pause_req) begin
      pause_pend_q <= 1'b1;
    end else if (paused_event || !unit_on) begin
      pause_pend_q <= 1'b0;
    end
  end
  // link event pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_boundary_event <= 1'b0;
      paused_event <= 1'b0;
    end else begin
      byte_boundary_event <= ack_done;
      paused_event <= ack_done & read_txn & pause_pend_q & (phase_q == imc_pkg::IMC_PH_DATA);
    end
  end

  // ****************************************************************
  // error sources
  // ****************************************************************
  // received byte waiting for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pend_q <= 1'b0;
    end else if (rx_byte_ready_event) begin
      rx_pend_q <= 1'b1;
    end else if (rx_hold_read) begin
      rx_pend_q <= 1'b0;
    end
  end
  always_comb begin
    err_set = `IMC_RST_ERRORS;
    // new byte over an unread one
    err_set[`IMC_BIT_OVERRUN] = rx_byte_ready_event & rx_pend_q & ~rx_hold_read;
    err_set[`IMC_BIT_ADDR_NACK] = ack_done & nack_q & (phase_q == imc_pkg::IMC_PH_ADDRESS);
    err_set[`IMC_BIT_DATA_NACK] = ack_done & nack_q & ~read_txn &
                                  (phase_q == imc_pkg::IMC_PH_DATA);
  end
  assign err_clr = (wr && paddr == `IMC_OFS_ERROR_SOURCE) ? pwdata[2:0] : `IMC_RST_ERRORS;
  imc_sticky #(.W(3)) u_err (
    .pclk(pclk),
    .presetn(presetn),
    .set(err_set),
    .clr(err_clr),
    .flag_q(err_q)
  );
  // error on a newly set flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_event <= 1'b0;
    end else begin
      error_event <= |(err_set & ~err_q);
    end
  end

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  assign ev_set = {paused_event, byte_boundary_event, error_event,
                   tx_byte_sent_event, rx_byte_ready_event, bus_halted_event};
  assign ev_clr = (rd && paddr == `IMC_OFS_EVENT_STATUS) ? stat_seen_q : `IMC_RST_EVENTS;
  imc_sticky #(.W(6)) u_stat (
    .pclk(pclk),
    .presetn(presetn),
    .set(ev_set),
    .clr(ev_clr),
    .flag_q(ev_stat)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inten_q <= `IMC_RST_EVENTS;
    end else if (wr && paddr == `IMC_OFS_INT_ENABLE) begin
      inten_q <= inten_q | imc_unpack(pwdata);
    end else if (wr && paddr == `IMC_OFS_INT_DISABLE) begin
      inten_q <= inten_q & ~imc_unpack(pwdata);
    end
  end
  // level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((ev_stat | ev_set) & inten_q & ~ev_clr);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_field_q <= `IMC_UNIT_OFF_CODE;
      two_wire_unit_on <= 1'b0;
    end else begin
      if (wr && paddr == `IMC_OFS_UNIT_ENABLE) begin
        unit_field_q <= pwdata[`IMC_UNIT_FIELD_W-1:0];
      end
      two_wire_unit_on <= unit_on;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  // read mux, latched at setup
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      `IMC_OFS_INT_ENABLE: rd_val = imc_pack(inten_q);
      `IMC_OFS_INT_DISABLE: rd_val = imc_pack(inten_q);
      `IMC_OFS_ERROR_SOURCE: rd_val = {29'h0, err_q};
      `IMC_OFS_UNIT_ENABLE: rd_val = {28'h0, unit_field_q};
      `IMC_OFS_EVENT_STATUS: rd_val = imc_pack(ev_stat);
      default: mapped = 1'b0;
    endcase
  end
  // no wait state: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      stat_seen_q <= `IMC_RST_EVENTS;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
        stat_seen_q <= ev_stat;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_dis_write;
    wr && paddr == `IMC_OFS_INT_DISABLE && pwdata[`IMC_BIT_ERROR];
  endsequence
  a_disable_clears_enable: assert property (s_dis_write |=> !inten_q[3])
    else $error("disable write left interrupt enabled");
  a_pause_needs_read: assert property (paused_event |-> $past(read_txn) && $past(pause_pend_q))
    else $error("paused event without read and request");
  a_pause_after_ack: assert property (paused_event |-> $past(ack_done))
    else $error("paused event outside ack slot");
  a_overrun_sets: assert property (
    rx_byte_ready_event && rx_pend_q && !rx_hold_read |=> err_q[`IMC_BIT_OVERRUN])
    else $error("overrun flag not set");
  a_addr_nack_holds: assert property (
    err_q[`IMC_BIT_ADDR_NACK] && !err_clr[`IMC_BIT_ADDR_NACK] |=> err_q[`IMC_BIT_ADDR_NACK])
    else $error("address nack flag dropped");
  a_data_nack_sets: assert property (err_set[`IMC_BIT_DATA_NACK] |=> err_q[`IMC_BIT_DATA_NACK])
    else $error("data nack flag not set");
  a_unit_on_code: assert property (
    two_wire_unit_on |-> $past(unit_field_q) == `IMC_UNIT_ON_CODE)
    else $error("unit on with wrong code");
  a_error_event_flag: assert property (|(err_set & ~err_q) |=> error_event ##1 ev_stat[3])
    else $error("error event not raised");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held two cycles");

endmodule

// [tb/imc_slave_model.sv]
/*
 * holds a behavioural two-wire slave that answers the ack slot of each byte.
 * assumes scl is made by the bench and stands high between frames, and that
 * sda is open drain with a pull-up worked out by the bench.
 */
`timescale 1ns/10ps

module imc_slave_model (
  // bus side
  input wire logic scl,
  input wire logic frame,
  // control from the bench
  input wire logic ack_en,
  // open-drain pull-down
  output logic sda_low
);
  // ****************************************************************
  // falling edges of scl since the frame started
  // ****************************************************************
  int cnt = 0;

  // counts falls; a frame start clears it
  always @(negedge scl or posedge frame) begin
    if (frame) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // pulls low in the ack slot only, released at every other time
  assign sda_low = ack_en && (cnt > 0) && (cnt % 9 == 0);
endmodule

// [tb/i2c_master_irq_error_ctrl_tb.sv]
/*
 * holds the self-checking bench of the two-wire master control slice.
 * assumes the design files and the constants header are compiled first.
 */
`timescale 1ns/10ps
`include "imc_consts.svh"

module i2c_master_irq_error_ctrl_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, ev, irq, unit_on, bbe, pse, ere;
  logic halt = 0, rxr = 0, txs = 0, hold_rd = 0, start = 0, rd_txn = 0, preq = 0;
  logic scl = 1, m_low = 0, s_low, ack_en = 0;
  int miscompares = 0, tests_run = 0, bb_cnt = 0, ps_cnt = 0, er_cnt = 0, b0, p0, e0;
  localparam logic [31:0] ALL = 32'h00044286; // six event bits
  wire sda = !(m_low || s_low); // pull-up unless someone pulls low

`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end

  always #10 pclk = ~pclk;

  // counts the event pulses of the design
  always @(posedge pclk) begin
    if (bbe === 1'b1) bb_cnt++;
    if (pse === 1'b1) ps_cnt++;
    if (ere === 1'b1) er_cnt++;
  end

  imc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_halted_event(halt), .rx_byte_ready_event(rxr),
    .tx_byte_sent_event(txs), .rx_hold_read(hold_rd), .xfer_start(start),
    .read_txn(rd_txn), .pause_req(preq), .scl_in(scl), .sda_in(sda), .irq(irq),
    .two_wire_unit_on(unit_on), .byte_boundary_event(bbe), .paused_event(pse),
    .error_event(ere));

  imc_slave_model i_slave (.scl(scl), .frame(start), .ack_en(ack_en), .sda_low(s_low));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // prints the verdict and ends the run
  task conclude();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin miscompares++; conclude(); end
    rv = prdata;
    ev = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // read and compare
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK("prdata", e, rv)
  endtask

  // one-cycle pulse on the picked event input
  task pulse(input int k);
    @(posedge pclk);
    case (k)
      0: halt <= 1;
      1: rxr <= 1;
      2: hold_rd <= 1;
      3: start <= 1;
      4: preq <= 1;
      default: txs <= 1;
    endcase
    @(posedge pclk);
    {halt, rxr, hold_rd, start, preq, txs} <= 6'h00;
  endtask

  // nine bits at 160 ns; low[8] is the first bit, ones pull sda low
  task bus_byte(input logic [8:0] low, input logic ack);
    for (int i = 0; i < 9; i++) begin
      @(posedge pclk);
      scl <= 0; m_low <= low[8-i];
      // slave ack choice moves only with a fall, never while scl is high
      if (i == 0) ack_en <= ack;
      repeat (4) @(posedge pclk);
      scl <= 1;
      repeat (3) @(posedge pclk);
    end
  endtask

  // last fall closes the ack slot, then scl stands high
  task bus_end();
    @(posedge pclk);
    scl <= 0; m_low <= 0;
    repeat (4) @(posedge pclk);
    scl <= 1;
    repeat (10) @(posedge pclk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset values and an unmapped place
  task t_reset();
    rd(`IMC_OFS_INT_DISABLE, 32'h0);
    rd(`IMC_OFS_ERROR_SOURCE, 32'h0);
    rd(`IMC_OFS_UNIT_ENABLE, 32'h0);
    rd(12'h000, 32'h0);
    `CHK("pslverr", 1'b1, ev)
  endtask

  // disable by writing one, read shows enables
  task t_disable();
    apb(1, `IMC_OFS_INT_ENABLE, ALL);
    rd(`IMC_OFS_INT_DISABLE, ALL);
    pulse(0);
    pulse(5);
    repeat (3) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    apb(1, `IMC_OFS_INT_DISABLE, 32'h00000082);
    rd(`IMC_OFS_INT_DISABLE, ALL & ~32'h82);
    repeat (3) @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    rd(`IMC_OFS_EVENT_STATUS, 32'h00000082);
    rd(`IMC_OFS_EVENT_STATUS, 32'h0);
  endtask

  // unit enable code five only
  task t_unit();
    apb(1, `IMC_OFS_UNIT_ENABLE, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK("unit_on", 1'b0, unit_on)
    apb(1, `IMC_OFS_UNIT_ENABLE, 32'h5);
    repeat (2) @(posedge pclk);
    `CHK("unit_on", 1'b1, unit_on)
    apb(1, `IMC_OFS_UNIT_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK("unit_on", 1'b0, unit_on)
    apb(1, `IMC_OFS_UNIT_ENABLE, 32'h5);
    rd(`IMC_OFS_UNIT_ENABLE, 32'h5);
  endtask

  // overrun only when a byte lands before the previous read
  task t_overrun();
    e0 = er_cnt;
    pulse(1); pulse(2); pulse(1);
    rd(`IMC_OFS_ERROR_SOURCE, 32'h0);
    pulse(1);
    repeat (3) @(posedge pclk);
    rd(`IMC_OFS_ERROR_SOURCE, 32'h1);
    `CHK("err_pulses", e0 + 1, er_cnt)
    apb(1, `IMC_OFS_ERROR_SOURCE, 32'h1);
    rd(`IMC_OFS_ERROR_SOURCE, 32'h0);
  endtask

  // address nack, then data nack on a write
  task t_nack();
    rd_txn <= 0; b0 = bb_cnt; e0 = er_cnt; p0 = ps_cnt;
    pulse(3);
    bus_byte({~8'hA0, 1'b0}, 0);
    bus_end();
    rd(`IMC_OFS_ERROR_SOURCE, 32'h2);
    rd(`IMC_OFS_ERROR_SOURCE, 32'h2);
    apb(1, `IMC_OFS_ERROR_SOURCE, 32'h2);
    rd(`IMC_OFS_ERROR_SOURCE, 32'h0);
    // a pending pause must not fire in a write
    pulse(4);
    pulse(3);
    bus_byte({~8'hA0, 1'b0}, 1);
    bus_byte({~8'h5C, 1'b0}, 0);
    bus_end();
    rd(`IMC_OFS_ERROR_SOURCE, 32'h4);
    `CHK("err_pulses", 2, er_cnt - e0)
    `CHK("paused", p0, ps_cnt)
    apb(1, `IMC_OFS_ERROR_SOURCE, 32'h4);
    rd(`IMC_OFS_ERROR_SOURCE, 32'h0);
    // unit off drops the pending pause request
    apb(1, `IMC_OFS_UNIT_ENABLE, 32'h0);
    apb(1, `IMC_OFS_UNIT_ENABLE, 32'h5);
  endtask

  // paused only in a read after a pause request
  task t_pause();
    int pb;
    rd_txn <= 1;
    pb = ps_cnt;
    pulse(3);
    bus_byte({~8'hA1, 1'b0}, 1);
    // a read data ack without a request stays quiet
    bus_byte({8'h00, 1'b1}, 0);
    bus_end();
    `CHK("paused", pb, ps_cnt)
    pulse(4);
    bus_byte({8'h00, 1'b1}, 0);
    bus_end();
    `CHK("paused", pb + 1, ps_cnt)
    rd(`IMC_OFS_ERROR_SOURCE, 32'h0);
    rd_txn <= 0;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_disable();
    t_unit();
    t_overrun();
    b0 = bb_cnt;
    t_nack();
    `CHK("bb_pulses", 3, bb_cnt - b0)
    t_pause();
    conclude();
  end
endmodule
